// ===== core/ledslv_pkg.sv
// Package for the 36-channel LED register slave: register map, field layout, defaults.
// Assumes a write-only I2C target sampled from SCL/SDA pins.
package ledslv_pkg;

  localparam int          NUM_CH         = 36;
  localparam logic [4:0]  ADDR_FIXED     = 5'h0F;
  localparam logic [7:0]  OFS_SHUTDOWN   = 8'h00;
  localparam logic [7:0]  OFS_DUTY_FIRST = 8'h01;
  localparam logic [7:0]  OFS_DUTY_LAST  = 8'h24;
  localparam logic [7:0]  OFS_COMMIT     = 8'h25;
  localparam logic [7:0]  OFS_CTRL_FIRST = 8'h26;
  localparam logic [7:0]  OFS_CTRL_LAST  = 8'h49;
  localparam logic [7:0]  OFS_GLOBAL     = 8'h4A;
  localparam logic [7:0]  OFS_RATE       = 8'h4B;
  localparam logic [7:0]  OFS_DEFAULTS   = 8'h4F;
  localparam logic [7:0]  TRIGGER_VALUE  = 8'h00;
  localparam logic [7:0]  RESET_BYTE     = 8'h00;
  localparam int          BIT_SHUTDOWN   = 0;
  localparam int          BIT_ON         = 0;
  localparam int          BIT_SCALE_LO   = 1;
  localparam int          BIT_GLOBAL     = 0;
  localparam int          BIT_RATE       = 0;
  localparam logic [1:0]  STRAP_GND      = 2'h0;
  localparam logic [1:0]  STRAP_VCC      = 2'h3;
  localparam logic [1:0]  STRAP_SCL      = 2'h1;
  localparam logic [1:0]  STRAP_SDA      = 2'h2;

  // One completed register write carried from the link domain
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] data;
  } ledslv_wr_t;

  // Per-channel live settings
  typedef struct packed {
    logic       on;
    logic [1:0] scale;
    logic [7:0] duty;
  } ledslv_ch_t;

endpackage : ledslv_pkg

// ===== core/ledslv_top.sv
// I2C write-only LED register slave: link logic on SCL, register bank on mclk.
// Assumes the host is the only bus master and an external pull-up resolves SDA.
// Assumes the strap pins are static levels and SCL stands still between frames.
// A STOP only takes effect at the next SCL rising edge; a new START always restarts.
module ledslv_top #(
  parameter int NUM_CH = ledslv_pkg::NUM_CH
) (
  input  wire logic                      mclk,
  input  wire logic                      sys_rst,
  input  wire logic                      scl_in,
  input  wire logic                      sda_in,
  output logic                           sda_out,
  output logic                           sda_oe_n,
  input  wire logic                      strap_gnd,
  input  wire logic                      strap_vcc,
  input  wire logic                      strap_scl,
  input  wire logic                      strap_sda,
  output logic                           soft_shutdown_n,
  output logic                           global_off,
  output logic                           pwm_rate_bit,
  output ledslv_pkg::ledslv_ch_t [NUM_CH-1:0] ch_live,
  output logic [NUM_CH-1:0]              ch_drive_en
);

  typedef enum logic [1:0] {
    LS_IDLE,
    LS_ADDR,
    LS_REG,
    LS_DATA
  } ledslv_state_t;

  // Byte completed by the bit now on the data line
  function automatic logic [7:0] full_byte(input logic [7:0] sh, input logic b);
    return {sh[6:0], b};
  endfunction : full_byte

  // True when a write address selects channel idx of a bank starting at base
  function automatic logic ch_hit(input logic [7:0] addr, input logic [7:0] base,
                                  input int idx);
    return addr == base + 8'(idx);
  endfunction : ch_hit

  // Channel drive: on bit set, not in shutdown, not gated off globally
  function automatic logic ch_gate(input logic [7:0] ctrl, input logic [7:0] shut,
                                   input logic [7:0] glob);
    return ctrl[ledslv_pkg::BIT_ON] && shut[ledslv_pkg::BIT_SHUTDOWN]
           && !glob[ledslv_pkg::BIT_GLOBAL];
  endfunction : ch_gate

  // One-hot strap selection to address bits; nothing selected means ground
  function automatic logic [1:0] strap_code(input logic [3:0] sel);
    logic [1:0] code;
    code = ledslv_pkg::STRAP_GND;
    if (sel[1]) begin
      code = ledslv_pkg::STRAP_VCC;
    end else if (sel[2]) begin
      code = ledslv_pkg::STRAP_SCL;
    end else if (sel[3]) begin
      code = ledslv_pkg::STRAP_SDA;
    end
    return code;
  endfunction : strap_code

  // Strap pins come from outside: three flops, a level counts once the last two agree
  logic [3:0] strap_m1_q;
  logic [3:0] strap_m2_q;
  logic [3:0] strap_m3_q;
  logic [3:0] strap_ok_q;

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      strap_m1_q <= 4'h0;
      strap_m2_q <= 4'h0;
      strap_m3_q <= 4'h0;
      strap_ok_q <= 4'h0;
    end else begin
      strap_m1_q <= {strap_sda, strap_scl, strap_vcc, strap_gnd};
      strap_m2_q <= strap_m1_q;
      strap_m3_q <= strap_m2_q;
      if (strap_m2_q == strap_m3_q) begin
        strap_ok_q <= strap_m3_q;
      end
    end
  end

  // Decoded strap, held in mclk and handed to the link domain as a slow level
  logic [1:0] strap_q;

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      strap_q <= ledslv_pkg::STRAP_GND;
    end else begin
      strap_q <= strap_code(strap_ok_q);
    end
  end

  // Strap enters the link domain as a level through two flops
  logic [1:0] strap_l1_q;
  logic [1:0] strap_l2_q;
  logic       lrst_a_q;
  logic       lrst_b_q;

  always_ff @(posedge scl_in or posedge sys_rst) begin
    if (sys_rst) begin
      strap_l1_q <= 2'h0;
      strap_l2_q <= 2'h0;
    end else begin
      strap_l1_q <= strap_q;
      strap_l2_q <= strap_l1_q;
    end
  end

  // START/STOP detection on SDA edges while SCL is high
  logic start_tgl_q;
  logic stop_tgl_q;

  always_ff @(negedge sda_in or posedge sys_rst) begin
    if (sys_rst) begin
      start_tgl_q <= 1'b0;
    end else if (scl_in) begin
      start_tgl_q <= ~start_tgl_q;
    end
  end

  always_ff @(posedge sda_in or posedge sys_rst) begin
    if (sys_rst) begin
      stop_tgl_q <= 1'b0;
    end else if (scl_in) begin
      stop_tgl_q <= ~stop_tgl_q;
    end
  end

  // Link-side record of which start the bit engine has consumed
  logic          start_seen_q;
  logic          bus_act;
  logic          framed_q;
  ledslv_state_t lstate_q;
  logic [2:0]    bit_cnt_q;
  logic [7:0]    shift_q;
  logic          ack_phase_q;
  logic          ack_pend_q;
  logic [7:0]    ptr_q;
  ledslv_pkg::ledslv_wr_t wr_q;
  logic          wr_tgl_q;
  logic          stop_seen_q;

  assign bus_act = (start_tgl_q != start_seen_q);

  // Bit engine: sample SDA on SCL rising edge
  always_ff @(posedge scl_in or posedge sys_rst) begin
    if (sys_rst) begin
      start_seen_q <= 1'b0;
      stop_seen_q  <= 1'b0;
      lstate_q     <= LS_IDLE;
      bit_cnt_q    <= 3'h0;
      shift_q      <= 8'h00;
      ack_phase_q  <= 1'b0;
      ptr_q        <= 8'h00;
      wr_q         <= '0;
      wr_tgl_q     <= 1'b0;
    end else begin
      stop_seen_q <= stop_tgl_q;
      if (bus_act) begin
        start_seen_q <= start_tgl_q;
        lstate_q     <= LS_ADDR;
        bit_cnt_q    <= 3'h6;
        shift_q      <= {7'h00, sda_in};
        ack_phase_q  <= 1'b0;
      end else if (stop_seen_q != stop_tgl_q) begin
        lstate_q <= LS_IDLE;
      end else if (lstate_q != LS_IDLE) begin
        if (ack_phase_q) begin
          ack_phase_q <= 1'b0;
          bit_cnt_q   <= 3'h7;
        end else begin
          shift_q   <= full_byte(shift_q, sda_in);
          bit_cnt_q <= bit_cnt_q - 3'h1;
          if (bit_cnt_q == 3'h0) begin
            ack_phase_q <= 1'b1;
            unique case (lstate_q)
              LS_ADDR: begin
                if (full_byte(shift_q, sda_in) ==
                    {ledslv_pkg::ADDR_FIXED, strap_l2_q, 1'b0}) begin
                  lstate_q <= LS_REG;
                end else begin
                  lstate_q    <= LS_IDLE;
                  ack_phase_q <= 1'b0;
                end
              end
              LS_REG: begin
                ptr_q    <= full_byte(shift_q, sda_in);
                lstate_q <= LS_DATA;
              end
              LS_DATA: begin
                wr_q     <= '{addr: ptr_q, data: full_byte(shift_q, sda_in)};
                wr_tgl_q <= ~wr_tgl_q;
                ptr_q    <= ptr_q + 8'h01;
              end
              default: lstate_q <= LS_IDLE;
            endcase
          end
        end
      end
    end
  end

  // Acknowledge drive changes on SCL falling edge, held through the ninth pulse
  always_ff @(negedge scl_in or posedge sys_rst) begin
    if (sys_rst) begin
      ack_pend_q <= 1'b0;
    end else begin
      ack_pend_q <= ack_phase_q && (lstate_q != LS_IDLE);
    end
  end

  always_comb begin
    framed_q = ack_pend_q;
  end

  assign sda_out  = 1'b0;
  assign sda_oe_n = ~framed_q;

  // Write event crosses to mclk: three-flop toggle, data stable by then
  logic       wr_s1_q;
  logic       wr_s2_q;
  logic       wr_s3_q;
  logic       wr_fire;
  ledslv_pkg::ledslv_wr_t wr_cap_q;

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      wr_s1_q <= 1'b0;
      wr_s2_q <= 1'b0;
      wr_s3_q <= 1'b0;
    end else begin
      wr_s1_q <= wr_tgl_q;
      wr_s2_q <= wr_s1_q;
      wr_s3_q <= wr_s2_q;
    end
  end

  assign wr_fire = (wr_s2_q != wr_s3_q);

  // Capture the write once its toggle has settled; the link holds it for a whole byte
  logic wr_go_q;

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      wr_go_q  <= 1'b0;
      wr_cap_q <= '0;
    end else begin
      wr_go_q <= wr_fire;
      if (wr_fire) begin
        wr_cap_q <= wr_q;
      end
    end
  end

  // Register bank
  logic [7:0] shutdown_q;
  logic [7:0] global_q;
  logic [7:0] rate_q;
  logic [7:0] duty_sh_q [NUM_CH];
  logic [7:0] ctrl_sh_q [NUM_CH];
  logic [7:0] duty_q    [NUM_CH];
  logic [7:0] ctrl_q    [NUM_CH];
  logic       defaults_hit;
  logic       commit_hit;

  assign defaults_hit = wr_go_q && wr_cap_q.addr == ledslv_pkg::OFS_DEFAULTS
                        && wr_cap_q.data == ledslv_pkg::TRIGGER_VALUE;
  assign commit_hit   = wr_go_q && wr_cap_q.addr == ledslv_pkg::OFS_COMMIT
                        && wr_cap_q.data == ledslv_pkg::TRIGGER_VALUE;

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      shutdown_q <= ledslv_pkg::RESET_BYTE;
      global_q   <= ledslv_pkg::RESET_BYTE;
      rate_q     <= ledslv_pkg::RESET_BYTE;
    end else if (defaults_hit) begin
      shutdown_q <= ledslv_pkg::RESET_BYTE;
      global_q   <= ledslv_pkg::RESET_BYTE;
      rate_q     <= ledslv_pkg::RESET_BYTE;
    end else if (wr_go_q) begin
      unique case (wr_cap_q.addr)
        ledslv_pkg::OFS_SHUTDOWN: shutdown_q <= wr_cap_q.data;
        ledslv_pkg::OFS_GLOBAL:   global_q   <= wr_cap_q.data;
        ledslv_pkg::OFS_RATE:     rate_q     <= wr_cap_q.data;
        default: ;
      endcase
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      for (int i = 0; i < NUM_CH; i++) begin
        duty_sh_q[i] <= ledslv_pkg::RESET_BYTE;
        ctrl_sh_q[i] <= ledslv_pkg::RESET_BYTE;
        duty_q[i]    <= ledslv_pkg::RESET_BYTE;
        ctrl_q[i]    <= ledslv_pkg::RESET_BYTE;
      end
    end else if (defaults_hit) begin
      for (int i = 0; i < NUM_CH; i++) begin
        duty_sh_q[i] <= ledslv_pkg::RESET_BYTE;
        ctrl_sh_q[i] <= ledslv_pkg::RESET_BYTE;
        duty_q[i]    <= ledslv_pkg::RESET_BYTE;
        ctrl_q[i]    <= ledslv_pkg::RESET_BYTE;
      end
    end else if (commit_hit) begin
      for (int i = 0; i < NUM_CH; i++) begin
        duty_q[i] <= duty_sh_q[i];
        ctrl_q[i] <= ctrl_sh_q[i];
      end
    end else if (wr_go_q) begin
      // Unmapped addresses match no bank and fall through untouched
      for (int i = 0; i < NUM_CH; i++) begin
        if (ch_hit(wr_cap_q.addr, ledslv_pkg::OFS_DUTY_FIRST, i)) begin
          duty_sh_q[i] <= wr_cap_q.data;
        end
        if (ch_hit(wr_cap_q.addr, ledslv_pkg::OFS_CTRL_FIRST, i)) begin
          ctrl_sh_q[i] <= wr_cap_q.data;
        end
      end
    end
  end

  // Outputs toward the PWM and current-sink stages
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      soft_shutdown_n <= 1'b0;
      global_off      <= 1'b0;
      pwm_rate_bit    <= 1'b0;
      ch_live         <= '0;
      ch_drive_en     <= '0;
    end else begin
      soft_shutdown_n <= shutdown_q[ledslv_pkg::BIT_SHUTDOWN];
      global_off      <= global_q[ledslv_pkg::BIT_GLOBAL];
      pwm_rate_bit    <= rate_q[ledslv_pkg::BIT_RATE];
      for (int i = 0; i < NUM_CH; i++) begin
        ch_live[i].duty  <= duty_q[i];
        ch_live[i].scale <= ctrl_q[i][ledslv_pkg::BIT_SCALE_LO +: 2];
        ch_live[i].on    <= ctrl_q[i][ledslv_pkg::BIT_ON];
        ch_drive_en[i]   <= ch_gate(ctrl_q[i], shutdown_q, global_q);
      end
    end
  end

endmodule : ledslv_top

// ===== tb/ledslv_top_assertions.sv
// Checker for the LED register slave: acknowledge timing and output gating.
// Assumes it is bound to ledslv_top and sees only its ports.
module ledslv_top_chk #(
  parameter int NUM_CH = 36
) (
  input wire logic                              mclk,
  input wire logic                              sys_rst,
  input wire logic                              scl_in,
  input wire logic                              sda_in,
  input wire logic                              sda_out,
  input wire logic                              sda_oe_n,
  input wire logic                              soft_shutdown_n,
  input wire logic                              global_off,
  input wire logic                              pwm_rate_bit,
  input wire ledslv_pkg::ledslv_ch_t [NUM_CH-1:0] ch_live,
  input wire logic [NUM_CH-1:0]                 ch_drive_en
);
  logic [NUM_CH-1:0] on_vec;
  logic [3:0]        since_ack_q;
  for (genvar i = 0; i < NUM_CH; i++) begin : g_on
    assign on_vec[i] = ch_live[i].on;
  end
  // Cycles since the device last pulled the data line
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) since_ack_q <= 4'hF;
    else if (!sda_oe_n) since_ack_q <= 4'h0;
    else if (since_ack_q != 4'hF) since_ack_q <= since_ack_q + 4'h1;
  end
  chk_ack_wire_low : assert property (
    @(posedge mclk) disable iff (sys_rst) !sda_oe_n |-> !sda_out && !sda_in)
    else $error("ack does not pull data low");
  chk_ack_one_pulse : assert property (
    @(posedge scl_in) disable iff (sys_rst) !sda_oe_n |=> sda_oe_n)
    else $error("ack spans two clock pulses");
  chk_ack_byte_gap : assert property (
    @(posedge scl_in) disable iff (sys_rst) !sda_oe_n |-> $past(sda_oe_n, 8))
    else $error("ack sooner than eight bits");
  chk_drive_gate : assert property (
    @(posedge mclk) disable iff (sys_rst)
    ch_drive_en == (on_vec & {NUM_CH{soft_shutdown_n && !global_off}}))
    else $error("drive enable mismatch");
  chk_global_off : assert property (
    @(posedge mclk) disable iff (sys_rst) global_off |-> ch_drive_en == '0)
    else $error("channel on while gated");
  chk_shutdown_off : assert property (
    @(posedge mclk) disable iff (sys_rst) !soft_shutdown_n |-> ch_drive_en == '0)
    else $error("channel on in shutdown");
  chk_update_near_ack : assert property (
    @(posedge mclk) disable iff (sys_rst)
    $changed({soft_shutdown_n, global_off, pwm_rate_bit, ch_live}) |-> since_ack_q <= 4'hA)
    else $error("settings changed without a write");
  cov_ack : cover property (@(posedge scl_in) disable iff (sys_rst) !sda_oe_n);
  cov_commit : cover property (@(posedge mclk) disable iff (sys_rst) $changed(ch_live));
  cov_gate : cover property (@(posedge mclk) disable iff (sys_rst) $rose(global_off));
endmodule : ledslv_top_chk

bind ledslv_top ledslv_top_chk #(.NUM_CH(NUM_CH)) u_chk (.mclk, .sys_rst, .scl_in, .sda_in,
  .sda_out, .sda_oe_n, .soft_shutdown_n, .global_off, .pwm_rate_bit, .ch_live, .ch_drive_en);

// ===== tb/ledslv_host_model.sv
// Host bus master model: drives the serial clock, pulls data low, samples acks.
// Assumes a pull-up resolves the data line from all pull-downs.
module ledslv_host_model (
  output logic      scl,
  output logic      sda_low,
  input  wire logic sda
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam time HALF = 15ns;
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task automatic start();
    #2 sda_low = 1'b0;
    #(HALF-2) scl = 1'b1;
    #HALF sda_low = 1'b1;
    #HALF scl = 1'b0;
  endtask : start
  // Two idle clocks with data released, then a start
  task automatic open();
    repeat (2) begin
      #HALF scl = 1'b0;
      #HALF scl = 1'b1;
    end
    start();
  endtask : open
  task automatic put(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      #2 sda_low = ~b[i];
      #(HALF-2) scl = 1'b1;
      #HALF scl = 1'b0;
    end
    #2 sda_low = 1'b0;
    #(HALF-2) scl = 1'b1;
    ack = sda;
    #HALF scl = 1'b0;
  endtask : put
  task automatic close();
    #2 sda_low = 1'b1;
    #(HALF-2) scl = 1'b1;
    #HALF sda_low = 1'b0;
    #HALF;
  endtask : close
endmodule : ledslv_host_model

// ===== tb/ledslv_top_tb.sv
// Testbench for the LED register slave: host model writes, bench model compares.
// Assumes package, design, checker and host model are compiled first.
module ledslv_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic                                  mclk, sys_rst, ack;
  logic [3:0]                            strap;
  logic [7:0]                            dev;
  logic                                  sda_out, sda_oe_n, soft_shutdown_n, global_off;
  logic                                  pwm_rate_bit;
  logic [35:0]                           ch_drive_en;
  ledslv_pkg::ledslv_ch_t [35:0]         ch_live;
  wire                                   scl, sda_low, sda;
  int     miscompares, check_count, shut, glob, rate, sd[36], sc[36], ld[36], lc[36], q[$];
  integer seed = 25824;
  logic [1:0] ads [4] = '{2'h0, 2'h3, 2'h1, 2'h2};
  assign sda = ~sda_low & (sda_oe_n | sda_out);
  ledslv_host_model host (.scl(scl), .sda_low(sda_low), .sda(sda));
  ledslv_top uut (.mclk(mclk), .sys_rst(sys_rst), .scl_in(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe_n(sda_oe_n), .strap_gnd(strap[0]), .strap_vcc(strap[1]),
    .strap_scl(strap[2]), .strap_sda(strap[3]), .soft_shutdown_n(soft_shutdown_n),
    .global_off(global_off), .pwm_rate_bit(pwm_rate_bit), .ch_live(ch_live),
    .ch_drive_en(ch_drive_en));
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR at %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : end_of_test
  task automatic dflt();
    shut = 0;
    glob = 0;
    rate = 0;
    foreach (sd[i]) begin
      sd[i] = 0;
      sc[i] = 0;
      ld[i] = 0;
      lc[i] = 0;
    end
  endtask : dflt
  task automatic mwr(input int a, input int d);
    if (a == 0) shut = d & 1;
    else if (a <= 36) sd[a-1] = d;
    else if (a == 37 && d == 0) begin
      ld = sd;
      lc = sc;
    end else if (a >= 38 && a <= 73) sc[a-38] = d;
    else if (a == 74) glob = d & 1;
    else if (a == 75) rate = d & 1;
    else if (a == 79 && d == 0) dflt();
  endtask : mwr
  task automatic cmp_all();
    repeat (12) @(negedge mclk);
    check(soft_shutdown_n, shut);
    check(global_off, glob);
    check(pwm_rate_bit, rate);
    for (int i = 0; i < 36; i++) begin
      check(ch_live[i], {lc[i][0], lc[i][2:1], ld[i][7:0]});
      check(ch_drive_en[i], lc[i][0] & shut & ~glob);
    end
  endtask : cmp_all
  task automatic snd(input logic [7:0] b);
    host.put(b, ack);
    check(ack, 1'b0);
  endtask : snd
  task automatic xfer(input int a, input int d[$]);
    host.open();
    snd(dev);
    snd(a[7:0]);
    foreach (d[k]) begin
      snd(d[k][7:0]);
      mwr((a + k) & 255, d[k]);
    end
    host.close();
    cmp_all();
  endtask : xfer
  task automatic nack(input logic [7:0] b);
    host.open();
    host.put(b, ack);
    check(ack, 1'b1);
    host.close();
    cmp_all();
  endtask : nack
  initial begin
    #1ms;
    miscompares++;
    end_of_test();
  end
  initial begin
    sys_rst = 1'b1;
    strap = 4'h1;
    dev = 8'h78;
    dflt();
    repeat (20) @(negedge mclk);
    sys_rst = 1'b0;
    cmp_all();
    for (int s = 0; s < 4; s++) begin
      @(negedge mclk);
      strap = 4'h0;
      strap[s] = 1'b1;
      dev = {5'h0F, ads[s], 1'b0};
      repeat (5) @(negedge mclk);
      nack(dev | 8'h01);
      nack({5'h0F, ads[s] ^ 2'h1, 1'b0});
      nack(8'($random(seed)) | 8'h01);
      xfer(8'h4B, '{s & 1});
    end
    xfer(8'h00, '{1});
    q = {};
    for (int i = 0; i < 36; i++) q.push_back($random(seed) & 255);
    xfer(8'h01, q);
    xfer(8'h25, '{8'h5A});
    q = {};
    for (int i = 0; i < 36; i++) q.push_back(($random(seed) & 8'hF9) | ((i & 3) << 1));
    xfer(8'h26, q);
    xfer(8'h25, '{0});
    xfer(8'h4A, '{1, 1, 8'hFF, 8'hFF, 8'hFF});
    xfer(8'h4A, '{0});
    host.open();
    snd(dev);
    snd(8'h05);
    snd(8'h33);
    mwr(5, 8'h33);
    host.start();
    snd(dev);
    snd(8'h25);
    snd(8'h00);
    mwr(37, 0);
    host.close();
    cmp_all();
    xfer(8'h4F, '{1});
    xfer(8'h4F, '{0});
    xfer(8'h00, '{1});
    @(negedge mclk);
    sys_rst = 1'b1;
    repeat (3) @(negedge mclk);
    sys_rst = 1'b0;
    dflt();
    cmp_all();
    xfer(8'h4A, '{1});
    end_of_test();
  end
endmodule : ledslv_top_tb
